// *** design/rcg_pkg.sv ***
// Package for the receiver control port, GPIO and pulse-width logic.
// Assumes one 100 MHz system clock and byte-wide registers on 7-bit addresses.
package rcg_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [6:0] ADDR_STATUS = 7'h06;
    localparam logic [6:0] ADDR_REMOTE_IN = 7'h07;
    localparam logic [6:0] ADDR_TX_MODE = 7'h1A;
    localparam logic [6:0] ADDR_OUT_CTRL = 7'h41;
    localparam logic [6:0] ADDR_PULSE_EN = 7'h42;
    localparam logic [6:0] ADDR_PULSE_DUTY = 7'h43;
    localparam logic [6:0] ADDR_INT_STATUS = 7'h4E;
    localparam logic [6:0] ADDR_COMMIT = 7'h4F;

    // ************************************************************
    // Field positions, masks and values
    // ************************************************************
    localparam int STA_EXEC_BIT = 7;
    localparam int STA_GPIO_BIT = 6;
    localparam int TRANSMITTER_MODE_REG_MIRROR_BIT = 3;
    localparam int OUT_HD3_BIT = 7;
    localparam int OUT_HD1_BIT = 5;
    localparam logic [7:0] OUT_MBZ_MASK = 8'h50;
    localparam logic [7:0] IN_MASK = 8'h0F;
    localparam logic [7:0] COMMIT_GO = 8'h01;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] PULSE_ON = 2'h3;

    // ************************************************************
    // Pulse timing: 16 MHz reference derived from the system clock
    // ************************************************************
    localparam logic [6:0] REF_CLK_MHZ = 7'h10;
    localparam logic [6:0] SYS_CLK_MHZ = 7'h64;
    localparam logic [7:0] PULSE_LAST = 8'hFE;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_SPI = 3'h1,
        MODE_TWI = 3'h2,
        MODE_GPIO = 3'h4
    } rcg_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] data;
    } rcg_req_s;

    typedef struct packed {
        logic valid;
        logic gpioMode;
        logic [7:0] outCtrl;
        logic [7:0] pulseEn;
        logic [7:0] pulseDuty;
    } rcg_cfg_s;

    typedef struct packed {
        logic misoData;
        logic sdaLow;
        logic sclLow;
    } rcg_slv_s;

    // Write hit on one register address
    function automatic logic wrHit(input rcg_req_s req, input logic [6:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

endpackage

// *** design/rcg_pulse_gen.sv ***
// Pulse-width generator for output 3.
// Assumes settings are held stable by the register file between local writes, commits and config loads.
`timescale 1ns/1ns
module rcg_pulse_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] enSel,
    input wire logic [5:0] rate,
    input wire logic [7:0] duty,
    output logic pulseOut
);
    logic [6:0] acc_q;
    logic [7:0] accSum;
    logic refTick;
    logic [5:0] pre_q;
    logic [7:0] cnt_q;
    logic running;

    // Fractional divider: 16 ticks per 100 clocks, jitter of one clock accepted
    assign running = (enSel == rcg_pkg::PULSE_ON);
    assign accSum = {1'b0, acc_q} + {1'b0, rcg_pkg::REF_CLK_MHZ};
    assign refTick = accSum >= {1'b0, rcg_pkg::SYS_CLK_MHZ};

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !running) begin
            acc_q <= 7'h00;
        end else if (refTick) begin
            acc_q <= 7'(accSum - {1'b0, rcg_pkg::SYS_CLK_MHZ});
        end else begin
            acc_q <= accSum[6:0];
        end
    end

    // Prescaler stretches each count to 1 + rate reference ticks
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !running) begin
            pre_q <= 6'h00;
            cnt_q <= 8'h00;
        end else if (refTick) begin
            if (pre_q == rate) begin
                pre_q <= 6'h00;
                cnt_q <= (cnt_q == rcg_pkg::PULSE_LAST) ? 8'h00 : cnt_q + 8'h01;
            end else begin
                pre_q <= pre_q + 6'h01;
            end
        end
    end

    // High for duty counts of each 255-count period
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulseOut <= 1'b0;
        end else begin
            pulseOut <= running && (cnt_q < duty);
        end
    end

    period_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cnt_q == rcg_pkg::PULSE_LAST && pre_q == rate && refTick && running) |=> cnt_q == 8'h00)
        else $error("pulse period does not wrap after 255 counts");
endmodule

// *** design/rcg_pin_mux.sv ***
// Pin function selector: serial slave pins or GPIO pins.
// Assumes the serial slave engine outside reads the pin inputs directly.
`timescale 1ns/1ns
module rcg_pin_mux (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic gpioMode,
    input wire logic pin1In,
    input wire logic [3:0] doBits,
    input wire logic [1:0] hiDriveReq,
    input wire logic irqLevel,
    input wire rcg_pkg::rcg_slv_s slv,
    output rcg_pkg::rcg_mode_e mode,
    output logic pin1Out,
    output logic pin1Oe,
    output logic pin2Out,
    output logic pin2Oe,
    output logic pin3Out,
    output logic pin3Oe,
    output logic pin36Out,
    output logic [1:0] hiDrive
);
    // Configuration bit first, then the select pin picks the serial flavour
    always_comb begin
        if (gpioMode) begin
            mode = rcg_pkg::MODE_GPIO;
        end else if (pin1In) begin
            mode = rcg_pkg::MODE_TWI;
        end else begin
            mode = rcg_pkg::MODE_SPI;
        end
    end

    // Registered pin drive; GPIO values never reach pins in slave mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin1Out <= 1'b0;
            pin1Oe <= 1'b0;
            pin2Out <= 1'b0;
            pin2Oe <= 1'b0;
            pin3Out <= 1'b0;
            pin3Oe <= 1'b0;
            pin36Out <= 1'b0;
            hiDrive <= 2'h0;
        end else begin
            case (mode)
                rcg_pkg::MODE_GPIO: begin
                    pin1Out <= doBits[2];
                    pin1Oe <= 1'b1;
                    pin2Out <= doBits[1];
                    pin2Oe <= 1'b1;
                    pin3Out <= doBits[0];
                    pin3Oe <= 1'b1;
                    pin36Out <= doBits[3];
                    hiDrive <= hiDriveReq;
                end
                rcg_pkg::MODE_TWI: begin
                    // Open drain: only ever pull low
                    pin1Out <= 1'b0;
                    pin1Oe <= 1'b0;
                    pin2Out <= 1'b0;
                    pin2Oe <= slv.sdaLow;
                    pin3Out <= 1'b0;
                    pin3Oe <= slv.sclLow;
                    pin36Out <= irqLevel;
                    hiDrive <= 2'h0;
                end
                default: begin
                    pin1Out <= 1'b0;
                    pin1Oe <= 1'b0;
                    pin2Out <= slv.misoData;
                    pin2Oe <= 1'b1;
                    pin3Out <= 1'b0;
                    pin3Oe <= 1'b0;
                    pin36Out <= irqLevel;
                    hiDrive <= 2'h0;
                end
            endcase
        end
    end
endmodule

// *** design/rcg_receiver_ctrl.sv ***
// Receiver control-port selection, GPIO registers and pulse output.
// Assumes the serial slave engine and the control channel deliver decoded
// byte requests, one per cycle, synchronous to clk_sys.
`timescale 1ns/1ns
module rcg_receiver_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire rcg_pkg::rcg_req_s localReq,
    output logic [7:0] localRdata,
    input wire rcg_pkg::rcg_req_s remoteReq,
    input wire rcg_pkg::rcg_cfg_s cfgLoad,
    input wire logic linkUp,
    input wire logic execOk,
    input wire logic [7:0] intEvents,
    input wire logic [2:0] txPinLevels,
    input wire logic masterBusActive,
    input wire logic [2:0] masterBusEn,
    input wire rcg_pkg::rcg_slv_s slaveDrive,
    input wire logic pin1In,
    input wire logic pin4In,
    input wire logic pin6In,
    input wire logic [1:0] inLowPins,
    output logic pin1Out,
    output logic pin1Oe,
    output logic pin2Out,
    output logic pin2Oe,
    output logic pin3Out,
    output logic pin3Oe,
    output logic pin36Out,
    output logic [1:0] hiDrive,
    output logic spiActive,
    output logic twoWireActive,
    output logic [7:0] remoteInputLevels
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic gpioMode_q;
    logic [7:0] remoteIn_q;
    logic [7:0] outCtrl_q;
    logic [7:0] pulseEn_q;
    logic [7:0] pulseDuty_q;
    logic [7:0] outStage_q;
    logic [7:0] enStage_q;
    logic [7:0] dutyStage_q;
    logic mirror_q;
    logic [7:0] intStatus_q;
    logic remCommit;
    logic pulseOn;
    logic pulseOut;
    logic [2:0] lowBits;
    logic [3:0] doBits;
    logic [3:0] inPins;
    logic [7:0] readData;
    rcg_pkg::rcg_mode_e mode;

    assign remCommit = rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_COMMIT)
        && remoteReq.data == rcg_pkg::COMMIT_GO;
    assign inPins = {pin4In, pin6In, inLowPins};
    assign remoteInputLevels = remoteIn_q;

    // ************************************************************
    // Interface choice bit
    // ************************************************************
    // Only local sources may change it; remote writes are dropped
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            gpioMode_q <= 1'b0;
        end else if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_STATUS)) begin
            gpioMode_q <= localReq.data[rcg_pkg::STA_GPIO_BIT];
        end else if (cfgLoad.valid) begin
            gpioMode_q <= cfgLoad.gpioMode;
        end
    end

    // ************************************************************
    // Remote input level register
    // ************************************************************
    // Pins feed it in GPIO mode; in slave mode the MCU may emulate them
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            remoteIn_q <= rcg_pkg::RESET_BYTE;
        end else if (gpioMode_q) begin
            remoteIn_q <= {4'h0, inPins};
        end else if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_REMOTE_IN)) begin
            remoteIn_q <= localReq.data & rcg_pkg::IN_MASK;
        end
    end

    // ************************************************************
    // Staging of values sent over the control channel; the mirror bit applies at once
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            outStage_q <= rcg_pkg::RESET_BYTE;
            enStage_q <= rcg_pkg::RESET_BYTE;
            dutyStage_q <= rcg_pkg::RESET_BYTE;
            mirror_q <= 1'b0;
        end else begin
            if (rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_OUT_CTRL)) begin
                outStage_q <= remoteReq.data & ~rcg_pkg::OUT_MBZ_MASK;
            end
            if (rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_PULSE_EN)) begin
                enStage_q <= remoteReq.data;
            end
            if (rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_PULSE_DUTY)) begin
                dutyStage_q <= remoteReq.data;
            end
            if (rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_TX_MODE)) begin
                mirror_q <= remoteReq.data[rcg_pkg::TRANSMITTER_MODE_REG_MIRROR_BIT];
            end
        end
    end

    // ************************************************************
    // Live output and pulse registers
    // ************************************************************
    // Local write wins a same-cycle commit; staging keeps the remote value
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            outCtrl_q <= rcg_pkg::RESET_BYTE;
        end else if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_OUT_CTRL)) begin
            outCtrl_q <= localReq.data & ~rcg_pkg::OUT_MBZ_MASK;
        end else if (remCommit) begin
            outCtrl_q <= outStage_q;
        end else if (cfgLoad.valid) begin
            outCtrl_q <= cfgLoad.outCtrl & ~rcg_pkg::OUT_MBZ_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pulseEn_q <= rcg_pkg::RESET_BYTE;
            pulseDuty_q <= rcg_pkg::RESET_BYTE;
        end else begin
            if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_PULSE_EN)) begin
                pulseEn_q <= localReq.data;
            end else if (remCommit) begin
                pulseEn_q <= enStage_q;
            end else if (cfgLoad.valid) begin
                pulseEn_q <= cfgLoad.pulseEn;
            end
            if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_PULSE_DUTY)) begin
                pulseDuty_q <= localReq.data;
            end else if (remCommit) begin
                pulseDuty_q <= dutyStage_q;
            end else if (cfgLoad.valid) begin
                pulseDuty_q <= cfgLoad.pulseDuty;
            end
        end
    end

    // ************************************************************
    // Local interrupt status copy
    // ************************************************************
    // Write one to clear; a new event in the clearing cycle still sets
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            intStatus_q <= rcg_pkg::RESET_BYTE;
        end else if (rcg_pkg::wrHit(localReq, rcg_pkg::ADDR_INT_STATUS)) begin
            intStatus_q <= (intStatus_q & ~localReq.data) | intEvents;
        end else begin
            intStatus_q <= intStatus_q | intEvents;
        end
    end

    // ************************************************************
    // Local read port
    // ************************************************************
    // Unmapped addresses read zero; no transmitter register is reachable
    always_comb begin
        if (localReq.addr == rcg_pkg::ADDR_STATUS) begin
            readData = {execOk, gpioMode_q, 6'h00};
        end else if (localReq.addr == rcg_pkg::ADDR_REMOTE_IN) begin
            readData = remoteIn_q;
        end else if (localReq.addr == rcg_pkg::ADDR_OUT_CTRL) begin
            readData = outCtrl_q;
        end else if (localReq.addr == rcg_pkg::ADDR_PULSE_EN) begin
            readData = pulseEn_q;
        end else if (localReq.addr == rcg_pkg::ADDR_PULSE_DUTY) begin
            readData = pulseDuty_q;
        end else if (localReq.addr == rcg_pkg::ADDR_INT_STATUS) begin
            readData = intStatus_q;
        end else begin
            readData = rcg_pkg::RESET_BYTE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            localRdata <= rcg_pkg::RESET_BYTE;
        end else if (localReq.rd) begin
            localRdata <= readData;
        end
    end

    // ************************************************************
    // Output selection
    // ************************************************************
    // Bus enables beat the mirror, which beats plain register data
    assign pulseOn = (pulseEn_q[7:6] == rcg_pkg::PULSE_ON);
    assign lowBits = masterBusActive ? masterBusEn
        : (mirror_q ? txPinLevels : outCtrl_q[2:0]);
    assign doBits = linkUp ? {pulseOn ? pulseOut : outCtrl_q[3], lowBits}
        : 4'h0;

    rcg_pulse_gen u_pulse (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .enSel(pulseEn_q[7:6]),
        .rate(pulseEn_q[5:0]),
        .duty(pulseDuty_q),
        .pulseOut(pulseOut)
    );

    rcg_pin_mux u_pins (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .gpioMode(gpioMode_q),
        .pin1In(pin1In),
        .doBits(doBits),
        .hiDriveReq({outCtrl_q[rcg_pkg::OUT_HD3_BIT] & linkUp,
            outCtrl_q[rcg_pkg::OUT_HD1_BIT] & linkUp}),
        .irqLevel(|intStatus_q),
        .slv(slaveDrive),
        .mode(mode),
        .pin1Out(pin1Out),
        .pin1Oe(pin1Oe),
        .pin2Out(pin2Out),
        .pin2Oe(pin2Oe),
        .pin3Out(pin3Out),
        .pin3Oe(pin3Oe),
        .pin36Out(pin36Out),
        .hiDrive(hiDrive)
    );

    assign spiActive = (mode == rcg_pkg::MODE_SPI);
    assign twoWireActive = (mode == rcg_pkg::MODE_TWI);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence stageOutSeq;
        rcg_pkg::wrHit(remoteReq, rcg_pkg::ADDR_OUT_CTRL) && !remCommit;
    endsequence
    sequence commitSeq;
        remCommit && !localReq.wr && !cfgLoad.valid;
    endsequence

    mode_select_a: assert property (
        !gpioMode_q |-> (spiActive == !pin1In) && (twoWireActive == pin1In))
        else $error("slave port flavour does not follow select pin");
    status_read_a: assert property (
        localReq.rd && localReq.addr == rcg_pkg::ADDR_STATUS
        |=> localRdata == {$past(execOk), $past(gpioMode_q), 6'h00})
        else $error("status register read wrong");
    remote_lock_a: assert property (
        !localReq.wr && !cfgLoad.valid |=> $stable(gpioMode_q))
        else $error("interface choice changed without a local source");
    gpio_pins_a: assert property (
        gpioMode_q |=> pin1Oe && pin2Oe && pin3Oe && pin1Out == $past(doBits[2])
        && pin36Out == $past(doBits[3]))
        else $error("GPIO pin mapping wrong");
    slave_detach_a: assert property (
        !gpioMode_q |=> !pin1Oe && !pin3Oe == !$past(twoWireActive && slaveDrive.sclLow)
        && hiDrive == 2'h0)
        else $error("GPIO state leaks onto slave pins");
    input_report_a: assert property (
        gpioMode_q ##1 gpioMode_q |-> remoteIn_q == {4'h0, $past(inPins)})
        else $error("input levels not reported");
    int_set_wins_a: assert property (
        |intEvents |=> (intStatus_q & $past(intEvents)) == $past(intEvents))
        else $error("interrupt event lost");
    commit_load_a: assert property (
        stageOutSeq ##1 commitSeq |=> outCtrl_q == $past(outStage_q)
        && pulseEn_q == $past(enStage_q) && pulseDuty_q == $past(dutyStage_q))
        else $error("commit did not load staged values");
    link_hold_a: assert property (
        !linkUp && gpioMode_q |=> !pin1Out && !pin2Out && !pin3Out && !pin36Out)
        else $error("outputs driven before link is up");
    zero_bits_a: assert property (
        (outCtrl_q & rcg_pkg::OUT_MBZ_MASK) == 8'h00)
        else $error("reserved output control bits set");
    out3_select_a: assert property (
        linkUp && !pulseOn |-> doBits[3] == outCtrl_q[3])
        else $error("output 3 not plain output while pulse disabled");
    mirror_copy_a: assert property (
        linkUp && mirror_q && !masterBusActive |-> doBits[2:0] == txPinLevels)
        else $error("transmitter inputs not mirrored");
endmodule

// *** dv/rcg_tx_model.sv ***
// Transmitter-side model: writes over the control channel.
// Assumes the channel takes one write on each rising edge of clk_sys.
`timescale 1ns/1ns
module rcg_tx_model (
    output rcg_pkg::rcg_req_s remoteReq,
    input wire logic clk_sys
);
    // ********************
    // Channel writes
    // ********************
    initial remoteReq = '0;
    // One write held across one edge; sent only while the bench is idle locally
    task automatic send(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 remoteReq = {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        #1 remoteReq = '0;
    endtask
    // Stage on one edge and commit on the very next one
    task automatic commit(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 remoteReq = {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        #1 remoteReq = {1'b1, 1'b0, rcg_pkg::ADDR_COMMIT, rcg_pkg::COMMIT_GO};
        @(posedge clk_sys);
        #1 remoteReq = '0;
    endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the receiver control, GPIO and pulse block.
// Assumes the transmitter model drives the remote channel.
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wd;
        logic [7:0] rd;
    } rcg_row_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    rcg_pkg::rcg_req_s localReq = '0;
    rcg_pkg::rcg_req_s remoteReq;
    rcg_pkg::rcg_cfg_s cfgLoad = '0;
    logic linkUp = 1'b0;
    logic [2:0] txPinLevels = 3'h0;
    logic pin1In = 1'b0;
    logic pin4In = 1'b0;
    logic pin6In = 1'b0;
    logic [1:0] inLowPins = 2'h0;
    logic [7:0] intEvents = 8'h00;
    logic masterBusActive = 1'b0;
    logic [2:0] masterBusEn = 3'h0;
    logic [7:0] localRdata, remoteInputLevels, got;
    logic pin1Out, pin1Oe, pin2Out, pin2Oe, pin3Out, pin3Oe, pin36Out, spiActive, twoWireActive;
    logic [1:0] hiDrive;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int hi, per;
    // Local accesses: write, then read back what the register keeps
    rcg_row_s rows [6] = '{'{7'h41, 8'hFF, 8'hAF}, '{7'h42, 8'h05, 8'h05},
        '{7'h43, 8'h80, 8'h80}, '{7'h30, 8'h55, 8'h00}, '{7'h07, 8'h0A, 8'h0A},
        '{7'h06, 8'h00, 8'h80}};

    always #5 clk_sys = ~clk_sys;
    // Hang guard: the pulse periods alone take about 8000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    rcg_tx_model tx (.remoteReq(remoteReq), .clk_sys(clk_sys));
    rcg_receiver_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .localReq(localReq),
        .localRdata(localRdata), .remoteReq(remoteReq), .cfgLoad(cfgLoad), .linkUp(linkUp),
        .execOk(1'b1), .intEvents(intEvents), .txPinLevels(txPinLevels),
        .masterBusActive(masterBusActive), .masterBusEn(masterBusEn), .slaveDrive('0),
        .pin1In(pin1In), .pin4In(pin4In),
        .pin6In(pin6In), .inLowPins(inLowPins), .pin1Out(pin1Out), .pin1Oe(pin1Oe),
        .pin2Out(pin2Out), .pin2Oe(pin2Oe), .pin3Out(pin3Out), .pin3Oe(pin3Oe),
        .pin36Out(pin36Out), .hiDrive(hiDrive), .spiActive(spiActive),
        .twoWireActive(twoWireActive), .remoteInputLevels(remoteInputLevels));

    // ********************
    // Drivers and compares
    // ********************
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic lwr(input logic [6:0] a, input logic [7:0] d);
        step();
        localReq = {1'b1, 1'b0, a, d};
        step();
        localReq = '0;
    endtask
    task automatic lrd(input logic [6:0] a, output logic [7:0] d);
        step();
        localReq = {1'b0, 1'b1, a, 8'h00};
        step();
        d = localRdata;
        localReq = '0;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic checkRange(input string what, input int lo, input int up, input int seen);
        compares++;
        if (seen < lo || seen > up) begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, up, seen);
        end
    endtask
    // Widths of one high phase and one full period of output 3
    task automatic measure();
        hi = 0;
        while (pin36Out !== 1'b0) step();
        while (pin36Out !== 1'b1) step();
        while (pin36Out === 1'b1) begin
            hi++;
            step();
        end
        per = hi;
        while (pin36Out !== 1'b1) begin
            per++;
            step();
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ********************
    // Scenarios
    // ********************
    initial begin
        repeat (2) step();
        rst_n = 1'b1;
        check("oe at reset", 8'h00, {5'h00, pin1Oe, pin2Oe, pin3Oe});
        foreach (rows[i]) begin
            lwr(rows[i].addr, rows[i].wd);
            lrd(rows[i].addr, got);
            check("reg read", rows[i].rd, got);
        end
        check("emulated inputs", 8'h0A, remoteInputLevels);
        // Event held through a clear of the same bit: the event must win
        intEvents = 8'h04;
        lwr(rcg_pkg::ADDR_INT_STATUS, 8'h04);
        intEvents = 8'h00;
        lrd(rcg_pkg::ADDR_INT_STATUS, got);
        check("event beats clear", 8'h05, {got[7:1], pin36Out});
        lwr(rcg_pkg::ADDR_INT_STATUS, 8'h04);
        lrd(rcg_pkg::ADDR_INT_STATUS, got);
        check("cleared", 8'h00, {got[7:1], pin36Out});
        check("select low", 8'h02, {6'h00, spiActive, twoWireActive});
        pin1In = 1'b1;
        step();
        check("select high", 8'h01, {6'h00, spiActive, twoWireActive});
        tx.send(rcg_pkg::ADDR_STATUS, 8'h40);
        lrd(rcg_pkg::ADDR_STATUS, got);
        check("remote mode write", 8'h80, got);
        step();
        cfgLoad = '{1'b1, 1'b1, 8'h05, 8'h00, 8'h00};
        step();
        cfgLoad = '0;
        repeat (3) step();
        check("before link", 8'h00, {2'h0, pin1Out, pin2Out, pin3Out, pin36Out, hiDrive});
        lrd(rcg_pkg::ADDR_STATUS, got);
        check("gpio status", 8'hC0, got);
        linkUp = 1'b1;
        pin4In = 1'b1;
        inLowPins = 2'h1;
        repeat (3) step();
        check("gpio pins", 8'h7A, {1'b0, pin1Oe, pin2Oe, pin3Oe, pin1Out, pin2Out, pin3Out, pin36Out});
        check("gpio inputs", 8'h09, remoteInputLevels);
        tx.send(rcg_pkg::ADDR_OUT_CTRL, 8'hA8);
        repeat (3) step();
        check("staged only", 8'h00, {5'h00, pin36Out, hiDrive});
        tx.commit(rcg_pkg::ADDR_OUT_CTRL, 8'hA8);
        repeat (3) step();
        check("committed", 8'h07, {2'h0, pin1Out, pin2Out, pin3Out, pin36Out, hiDrive});
        txPinLevels = 3'h6;
        tx.send(rcg_pkg::ADDR_TX_MODE, 8'h08);
        repeat (3) step();
        check("mirror", 8'h06, {5'h00, pin1Out, pin2Out, pin3Out});
        masterBusEn = 3'h5;
        masterBusActive = 1'b1;
        repeat (3) step();
        check("bus enables", 8'h05, {5'h00, pin1Out, pin2Out, pin3Out});
        masterBusActive = 1'b0;
        tx.send(rcg_pkg::ADDR_PULSE_DUTY, 8'h80);
        for (int r = 0; r < 2; r++) begin
            tx.commit(rcg_pkg::ADDR_PULSE_EN, 8'hC0 + 8'(r));
            measure();
            // 128 of 255 counts, each of (1 + r) reference ticks of 6.25 clocks
            checkRange("pulse high", 800 * (1 + r) - 1, 800 * (1 + r) + 1, hi);
            checkRange("pulse period", 1593 * (1 + r), 1594 * (1 + r), per);
        end
        tx.commit(rcg_pkg::ADDR_PULSE_EN, 8'h00);
        repeat (3) step();
        check("pulse off", 8'h01, {7'h00, pin36Out});
        rst_n = 1'b0;
        repeat (2) step();
        rst_n = 1'b1;
        check("oe after reset", 8'h00, {5'h00, pin1Oe, pin2Oe, pin3Oe});
        print_verdict();
    end
endmodule
